// >>> dv/tetc_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module tetc_top_tb
  import tetc_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic        pin;
  logic [3:0]  av_a;
  logic        av_r;
  logic        av_w;
  logic [3:0]  av_be;
  logic [31:0] av_d;
  logic [31:0] rdata;
  logic        wreq;
  logic        filt;
  logic        slv;
  logic        pulse;
  logic [15:0] cnt;
  int          fail_count;
  int          n_compared;
  int          n_pulse = 0;

  tetc_top u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_ext_trigger_input(pin),
    .i_address(av_a), .i_read(av_r), .i_write(av_w), .i_byteenable(av_be),
    .i_writedata(av_d), .o_readdata(rdata), .o_waitrequest(wreq),
    .o_ext_trigger_filtered(filt), .o_slave_trigger(slv), .o_count_pulse(pulse),
    .o_ext_count(cnt));
  tetc_trig_src u_src (.i_ref_clk(clk), .o_ext_trigger_input(pin));

  // Count pulses seen, so the pulse output is judged apart from the counter
  always @(posedge clk) begin
    if (pulse === 1'b1) n_pulse <= n_pulse + 1;
  end

  // 250 MHz kernel clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Avalon master: hold request until waitrequest seen low, take data there
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    av_w <= w;
    av_r <= !w;
    av_a <= a;
    av_d <= d;
    av_be <= be;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    av_w <= 1'b0;
    av_r <= 1'b0;
  endtask

  task automatic cfg(input logic [15:0] v);
    logic [31:0] q;
    bus(1, ADDR_SMCFG, {16'h0000, v}, 4'hF, q);
    repeat (20) @(posedge clk);
  endtask

  // Reset value, reserved bit, lanes, unmapped and read-only places
  task automatic t_regs();
    logic [31:0] q;
    bus(0, ADDR_SMCFG, 32'h0, 4'hF, q);
    `CHK(q, 32'h0000_0000, "config reset")
    bus(1, ADDR_SMCFG, 32'h0000_FFFF, 4'hF, q);
    bus(0, ADDR_SMCFG, 32'h0, 4'hF, q);
    `CHK(q, {16'h0000, 16'hFFFF & SMCFG_WMASK}, "reserved bit")
    bus(1, ADDR_SMCFG, 32'h0000_0000, 4'hF, q);
    bus(1, ADDR_SMCFG, 32'h0000_5555, 4'h2, q);
    bus(0, ADDR_SMCFG, 32'h0, 4'hF, q);
    `CHK(q, 32'h0000_5500, "byte lane")
    cfg(16'h0000);
    bus(0, 4'h4, 32'h0, 4'hF, q);
    `CHK(q, 32'h0000_0000, "unmapped read")
    bus(1, ADDR_EXT_COUNT, 32'h0000_1234, 4'hF, q);
    bus(0, ADDR_EXT_COUNT, 32'h0, 4'hF, q);
    `CHK(q[15:0], 16'h0000, "count read-only")
  endtask

  // Each prescaler code; eight edges give exact counts whatever the phase
  task automatic t_prescale();
    logic [15:0] c0;
    int          p0;
    for (int p = 0; p < 4; p++) begin
      cfg(16'h4000 | (16'(p) << 12));
      c0 = cnt;
      p0 = n_pulse;
      u_src.send(8, 4, 4);
      repeat (20) @(posedge clk);
      `CHK(cnt, 16'(c0 + (8 >> p)), "prescaled count")
      `CHK(n_pulse - p0, 8 >> p, "one pulse per counted edge")
    end
  endtask

  // Inverted sense: idle-low pin is active, falling edges are counted
  task automatic t_polarity();
    logic [15:0] c0;
    cfg(16'hC000);
    `CHK(filt, 1'b1, "inverted idle level")
    c0 = cnt;
    u_src.send(3, 6, 6);
    repeat (20) @(posedge clk);
    `CHK(cnt, 16'(c0 + 3), "falling edge count")
    cfg(16'h0000);
  endtask

  // Code 0011: five agreeing samples fall short of eight, twelve pass
  task automatic t_filter();
    logic [15:0] c0;
    cfg(16'h4300);
    c0 = cnt;
    u_src.send(1, 5, 20);
    `CHK(filt, 1'b0, "glitch blocked")
    `CHK(cnt, c0, "glitch not counted")
    u_src.send(1, 12, 20);
    `CHK(cnt, 16'(c0 + 1), "long pulse counted")
    cfg(16'h4400);
    u_src.send(1, 8, 30);
    `CHK(cnt, 16'(c0 + 1), "halved-rate glitch blocked")
    u_src.send(1, 20, 30);
    `CHK(cnt, 16'(c0 + 2), "halved-rate pulse counted")
  endtask

  // Trigger routing, mode 1 off, modes 0 and 1 together
  task automatic t_route();
    logic [15:0] c0;
    cfg(16'h0070);
    c0 = cnt;
    fork
      u_src.send(1, 30, 10);
      begin
        repeat (15) @(posedge clk);
        `CHK(slv, 1'b1, "routed to slave")
        `CHK(filt, 1'b1, "filtered high")
      end
    join
    `CHK(cnt, c0, "mode 1 off")
    cfg(16'h4007);
    u_src.send(1, 6, 6);
    cfg(16'h0077);
    u_src.send(1, 6, 6);
    repeat (20) @(posedge clk);
    `CHK(cnt, 16'(c0 + 2), "modes 0 and 1")
    cfg(16'h4060);
    fork
      u_src.send(1, 30, 10);
      begin
        repeat (15) @(posedge clk);
        `CHK(slv, 1'b0, "not routed")
      end
    join
    `CHK(cnt, 16'(c0 + 3), "other select counts")
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    av_a = 4'h0;
    av_r = 1'b0;
    av_w = 1'b0;
    av_be = 4'hF;
    av_d = 32'h0;
    fail_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_prescale();
    t_polarity();
    t_filter();
    t_route();
    tally_and_finish();
  end
endmodule

// >>> dv/tetc_trig_src.sv
`timescale 1ns/1ps
// Far-side trigger source; pin rests low between bursts, never free-running
module tetc_trig_src (
  input  wire logic i_ref_clk,
  output logic      o_ext_trigger_input
);
  initial o_ext_trigger_input = 1'b0;

  // Burst of n pulses, changed just after an edge; caller keeps hi and lo at four or more
  task automatic send(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      @(posedge i_ref_clk);
      o_ext_trigger_input <= 1'b1;
      repeat (hi) @(posedge i_ref_clk);
      o_ext_trigger_input <= 1'b0;
      repeat (lo - 1) @(posedge i_ref_clk);
    end
  endtask
endmodule

// >>> src/tetc_filter.sv
`timescale 1ns/1ps
// Event-counter glitch filter: output follows input after N agreeing samples
module tetc_filter
  import tetc_pkg::*;
#(
  parameter int CW = 4
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_sample_en,
  input  wire logic          i_din,
  input  wire logic [CW-1:0] i_n,
  output logic               o_dout
);

  initial begin
    if (CW < 4) $error("tetc_filter: CW must hold a count of 8");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_inc;
  wire           differ = i_din != o_dout;
  wire           reach  = cnt_inc >= i_n;

  assign cnt_inc = cnt_reg + {{(CW-1){1'b0}}, 1'b1};

  // Count consecutive disagreeing samples; one agreeing sample restarts the count
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
      o_dout  <= 1'b0;
    end else if (i_sample_en) begin
      if (!differ) begin
        cnt_reg <= '0;
      end else if (reach) begin
        cnt_reg <= '0;
        o_dout  <= i_din;
      end else begin
        cnt_reg <= cnt_inc;
      end
    end
  end

  // Output only moves on a sample after N-1 earlier disagreeing samples
  a_filter_change: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    $changed(o_dout) |-> $past(i_sample_en) && ($past(cnt_reg) + 1 >= $past(i_n))
                         && (o_dout == $past(i_din)))
    else $error("filter output moved before N agreeing samples");

  // Agreeing input never moves the output
  a_filter_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !differ |=> $stable(o_dout))
    else $error("filter output moved while input agreed");

endmodule

// >>> src/tetc_pkg.sv
// Shared constants for the external trigger conditioning block
package tetc_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [3:0]  ADDR_SMCFG     = 4'h8;
  localparam logic [3:0]  ADDR_EXT_COUNT = 4'hC;

  // Slave mode configuration layout and reset value
  localparam logic [15:0] SMCFG_RESET    = 16'h0000;
  localparam logic [15:0] SMCFG_WMASK    = 16'hFFF7;  // Bit 3 reserved, reads zero
  localparam int          POL_BIT        = 15;
  localparam int          MODE1_BIT      = 14;
  localparam int          PSC_LSB        = 12;
  localparam int          FLT_LSB        = 8;
  localparam int          MSS_BIT        = 7;
  localparam int          TRGSEL_LSB     = 4;
  localparam int          SMSEL_LSB      = 0;

  // Selector codes
  localparam logic [2:0]  TRGSEL_EXT_TRIGGER_FILTERED   = 3'h7;
  localparam logic [2:0]  SMSEL_EXT0     = 3'h7;
  localparam logic [1:0]  PSC_BYPASS     = 2'h0;

  // Timing: kernel clock period and least ratio of kernel clock to filtered trigger
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          MIN_CLK_RATIO  = 4;
  localparam int          MIN_TRIG_NS    = CLK_PERIOD_NS * MIN_CLK_RATIO;
  localparam int          MIN_TRIG_CYC   = (MIN_TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Filter code to sample-divider shift (0 means every kernel clock)
  function automatic logic [2:0] flt_shift(input logic [3:0] code);
    logic [2:0] s;
    s = 3'h0;
    if (code >= 4'hD) s = 3'h5;
    else if (code >= 4'hA) s = 3'h4;
    else if (code >= 4'h8) s = 3'h3;
    else if (code >= 4'h6) s = 3'h2;
    else if (code >= 4'h4) s = 3'h1;
    return s;
  endfunction

  // Filter code to required number of agreeing samples N
  function automatic logic [3:0] flt_count(input logic [3:0] code);
    logic [3:0] n;
    unique case (code)
      4'h0:                      n = 4'h1;
      4'h1:                      n = 4'h2;
      4'h2:                      n = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hB, 4'hE: n = 4'h6;
      4'hA, 4'hD:                n = 4'h5;
      default:                   n = 4'h8;
    endcase
    return n;
  endfunction

endpackage

// >>> src/tetc_top.sv
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// Behaviour
// - Polarity bit 1 makes low level or falling edge the active sense.
// - Mode 1 enable advances the counter on each active filtered trigger edge.
// - Modes 0 and 1 together use the filtered trigger as external clock.
// - Prescaler field 00 bypasses, 01 halves, 10 quarters, 11 divides by eight.
// - Filter is an event counter; output changes after N agreeing samples.
// - Filter field picks sampling rate and N, e.g. 0011 kernel clock, N=8.
// - Trigger select 111 routes the filtered trigger to the slave controller.
module tetc_top
  import tetc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ext_trigger_input,
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [3:0]  i_byteenable,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  output logic             o_ext_trigger_filtered,
  output logic             o_slave_trigger,
  output logic             o_count_pulse,
  output logic [CNT_W-1:0] o_ext_count
);

  initial begin
    if (CNT_W < 1 || CNT_W > 32) $error("tetc_top: CNT_W must be 1 to 32");
  end

  // Configuration register and its fields
  logic [15:0]     smcfg_reg;
  logic [15:0]     smcfg_next;
  wire             ext_trigger_polarity       = smcfg_reg[POL_BIT];
  wire             ext_clock_mode1_enable     = smcfg_reg[MODE1_BIT];
  wire [1:0]       ext_trigger_prescaler      = smcfg_reg[PSC_LSB +: 2];
  wire [3:0]       ext_trigger_filter_control = smcfg_reg[FLT_LSB +: 4];
  wire [2:0]       trigger_select             = smcfg_reg[TRGSEL_LSB +: 3];
  wire [2:0]       slave_mode_select          = smcfg_reg[SMSEL_LSB +: 3];

  // Bus decode
  wire             req       = i_read | i_write;
  wire             take_wr   = i_write & ~o_waitrequest;
  wire             take_rd   = i_read & o_waitrequest;
  wire             hit_smcfg = i_address == ADDR_SMCFG;
  wire             hit_count = i_address == ADDR_EXT_COUNT;
  wire [15:0]      be_mask   = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  wire [31:0]      rd_mux    = hit_smcfg ? {16'h0000, smcfg_reg}
                             : hit_count ? 32'(o_ext_count)
                             : 32'h0000_0000;

  // Byte-lane merge; reserved bit kept at zero
  assign smcfg_next = ((smcfg_reg & ~be_mask) | (i_writedata[15:0] & be_mask)) & SMCFG_WMASK;

  // One wait cycle per request: waitrequest drops the cycle after a request appears
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h0000_0000;
    end else begin
      o_waitrequest <= ~(req & o_waitrequest);
      if (take_rd) o_readdata <= rd_mux;
    end
  end

  // Write lands at the edge where waitrequest is seen low
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      smcfg_reg <= SMCFG_RESET;
    end else if (take_wr && hit_smcfg) begin
      smcfg_reg <= smcfg_next;
    end
  end

  // Stage 1: polarity; XOR keeps a rising edge as the active edge downstream
  logic            pol_reg;
  logic            pol_d_reg;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pol_reg   <= 1'b0;
      pol_d_reg <= 1'b0;
    end else begin
      pol_reg   <= i_ext_trigger_input ^ ext_trigger_polarity;
      pol_d_reg <= pol_reg;
    end
  end

  // Stage 2: prescaler counts active edges; bit k toggles every 2^k active edges, so it rises at 1/2^(k+1) of the rate
  logic [2:0]      psc_reg;
  wire             pol_rise = pol_reg & ~pol_d_reg;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      psc_reg <= 3'h0;
    end else if (pol_rise) begin
      psc_reg <= psc_reg + 3'h1;
    end
  end

  wire             psc_out = (ext_trigger_prescaler == PSC_BYPASS) ? pol_reg
                           : psc_reg[ext_trigger_prescaler - 2'h1];

  // Sample-rate divider for the filter; the dead-time clock equals the kernel clock here
  logic [4:0]      div_reg;
  wire [2:0]       flt_sh   = flt_shift(ext_trigger_filter_control);
  wire [3:0]       flt_n    = flt_count(ext_trigger_filter_control);
  wire [4:0]       div_mask = 5'((6'h01 << flt_sh) - 6'h01);
  wire             samp_en  = (div_reg & div_mask) == 5'h00;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  // Stage 3: filter fed from the prescaler output, never from the pin directly
  logic            flt_out;
  tetc_filter #(
    .CW          (4)
  ) u_filter (
    .i_ref_clk   (i_ref_clk),
    .i_nrst      (i_nrst),
    .i_sample_en (samp_en),
    .i_din       (psc_out),
    .i_n         (flt_n),
    .o_dout      (flt_out)
  );

  // External clock source: mode 1, or mode 0 with the filtered trigger selected
  wire             src_ext_trigger_filtered = ext_clock_mode1_enable
                             | ((slave_mode_select == SMSEL_EXT0)
                                && (trigger_select == TRGSEL_EXT_TRIGGER_FILTERED));
  wire             flt_rise  = flt_out & ~o_ext_trigger_filtered;

  // Outputs registered; filtered copy also serves as the edge-detect history
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_trigger_filtered <= 1'b0;
      o_slave_trigger        <= 1'b0;
      o_count_pulse          <= 1'b0;
    end else begin
      o_ext_trigger_filtered <= flt_out;
      o_slave_trigger        <= (trigger_select == TRGSEL_EXT_TRIGGER_FILTERED) & flt_out;
      o_count_pulse          <= flt_rise & src_ext_trigger_filtered;
    end
  end

  // Counter advanced by filtered trigger edges; read-only to software
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ext_count <= '0;
    end else if (flt_rise && src_ext_trigger_filtered) begin
      o_ext_count <= o_ext_count + CNT_W'(1);
    end
  end

  // Checks
  sequence s_req_wait;
    req && o_waitrequest;
  endsequence

  sequence s_answer;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  a_bus_answer: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    s_req_wait |=> s_answer)
    else $error("bus answer not one wait cycle");

  a_cfg_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (take_wr && hit_smcfg && i_byteenable == 4'hF) |=> smcfg_reg == $past(i_writedata[15:0] & SMCFG_WMASK))
    else $error("config write not stored");

  a_polarity_sense: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ($stable(smcfg_reg) && smcfg_reg[POL_BIT]) |-> pol_reg == !$past(i_ext_trigger_input))
    else $error("inverted polarity not applied");

  a_psc_bypass: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ext_trigger_prescaler == PSC_BYPASS |-> psc_out == pol_reg)
    else $error("prescaler bypass does not pass the trigger");

  a_psc_halve: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (ext_trigger_prescaler == 2'h1 && pol_rise) |=> psc_out != $past(psc_out))
    else $error("divide by 2 not toggling per edge");

  a_count_edge: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (ext_clock_mode1_enable && flt_rise) |=> o_count_pulse
                                             && o_ext_count == $past(o_ext_count) + CNT_W'(1))
    else $error("mode 1 edge not counted");

  a_count_off: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !src_ext_trigger_filtered |=> $stable(o_ext_count) && !o_count_pulse)
    else $error("counter moved with source disabled");

  a_mode_both: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (slave_mode_select == SMSEL_EXT0 && ext_clock_mode1_enable && flt_rise) |=> o_count_pulse)
    else $error("modes 0 and 1 together ignore filtered trigger");

  a_slave_route: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    trigger_select != TRGSEL_EXT_TRIGGER_FILTERED |=> !o_slave_trigger)
    else $error("filtered trigger routed without select 111");

  a_filter_n8: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (ext_trigger_filter_control == 4'h3 && $stable(ext_trigger_filter_control))
      |-> flt_n == 4'h8 && samp_en)
    else $error("code 0011 not kernel clock with N of 8");

endmodule
